/* rtl/rsef_pkg.sv */
/*
  Package for the receive stream output stage: widths, mode codes,
  latency figures and the beat carrier struct.
  Assumes one core clock and a synchronous active-high reset.
*/
package rsef_pkg;
  localparam int DATA_W = 256;
  localparam int EMPTY_W = 2;
  localparam int EOP_W = 2;
  localparam int READY_LATENCY = 2;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] WIDTH_64 = 2'h0;
  localparam logic [1:0] WIDTH_128 = 2'h1;
  localparam logic [1:0] WIDTH_256 = 2'h2;
  localparam int QWORD_W = 64;
  localparam int HALF_W = 128;

  typedef struct packed {
    logic [DATA_W-1:0] payload;
    logic [EOP_W-1:0] first;
    logic [EOP_W-1:0] last;
    logic [EMPTY_W-1:0] empty;
  } rsef_beat_type;

  localparam int BEAT_W = $bits(rsef_beat_type);
endpackage

/* rtl/rsef_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes writer and reader share the clock; reset empties it.
*/
`timescale 1ns/1ns
module rsef_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* rtl/rsef_rx_stream.sv */
/*
  Receive stream output stage: packets from the transaction layer enter
  a FIFO and leave toward the application under a ready latency of two.
  The empty-qword code is cleaned per configured width and mode.
  Assumes the application keeps to the ready latency and that the
  source side honours src_ready.
*/
`timescale 1ns/1ns
module rsef_rx_stream (
  input wire logic clock,
  input wire logic srst,
  input wire logic [1:0] cfg_width,
  input wire logic cfg_multi_packet,
  input wire logic src_valid,
  output logic src_ready,
  input wire rsef_pkg::rsef_beat_type src_beat,
  input wire logic recv_sink_accept,
  output logic recv_beat_qualifier,
  output logic [rsef_pkg::DATA_W-1:0] recv_payload_bus,
  output logic [rsef_pkg::EOP_W-1:0] recv_packet_first,
  output logic [rsef_pkg::EOP_W-1:0] recv_packet_last,
  output logic [rsef_pkg::EMPTY_W-1:0] recv_empty_qwords
);
  import rsef_pkg::*;

  rsef_beat_type in_beat;
  rsef_beat_type head_beat;
  logic head_valid;
  logic accept_q;
  logic ready_cycle;
  logic send;
  logic [1:0] stall_run;
  logic [1:0] next_stall_run;
  wire multi = cfg_multi_packet && (cfg_width == WIDTH_256);

  // empty code cleaned to the encoding of the configured width
  function automatic logic [EMPTY_W-1:0] clean_empty(
    input logic [1:0] width,
    input logic multi_mode,
    input logic [EOP_W-1:0] last,
    input logic [EMPTY_W-1:0] empty
  );
    logic [EMPTY_W-1:0] result;
    result = '0;
    if (width == WIDTH_128) begin
      result = {1'b0, empty[0] & last[0]};
    end else if (width == WIDTH_256 && multi_mode) begin
      result = {empty[1] & last[1], empty[0] & last[0]};
    end else if (width == WIDTH_256) begin
      result = last[0] ? empty : '0;
    end
    return result;
  endfunction

  // single-packet and narrow modes use only bit 0 of first and last
  wire [EOP_W-1:0] last_mask = multi ? 2'h3 : 2'h1;
  wire [EOP_W-1:0] clean_last = src_beat.last & last_mask;

  always_comb begin
    in_beat = src_beat;
    in_beat.first = src_beat.first & last_mask;
    in_beat.last = clean_last;
    in_beat.empty = clean_empty(cfg_width, multi, clean_last,
      src_beat.empty);
  end

  rsef_fifo #(
    .WIDTH(BEAT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .srst(srst),
    .in_valid(src_valid),
    .in_ready(src_ready),
    .in_data(in_beat),
    .out_valid(head_valid),
    .out_ready(send),
    .out_data(head_beat)
  );

  // the application runs on this clock, so accept is not synchronised;
  // this flop and the output register together make the latency of two,
  // a second flop here would push valid one cycle past the ready cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      accept_q <= 1'b0;
    end else begin
      accept_q <= recv_sink_accept;
    end
  end

  // accept seen in cycle n enables a beat in cycle n+2
  assign ready_cycle = accept_q;
  assign send = ready_cycle && head_valid;

  // run of accept-low cycles, saturating; feeds the stall check only
  assign next_stall_run = recv_sink_accept ? 2'h0 :
    (stall_run == 2'h3) ? stall_run : stall_run + 2'h1;

  always_ff @(posedge clock) begin
    if (srst) begin
      stall_run <= 2'h0;
    end else begin
      stall_run <= next_stall_run;
    end
  end

  logic [DATA_W-1:0] next_payload;
  assign next_payload = send ? head_beat.payload : recv_payload_bus;

  always_ff @(posedge clock) begin
    if (srst) begin
      recv_beat_qualifier <= 1'b0;
      recv_payload_bus <= '0;
      recv_packet_first <= '0;
      recv_packet_last <= '0;
      recv_empty_qwords <= '0;
    end else begin
      recv_beat_qualifier <= send;
      recv_payload_bus <= next_payload;
      recv_packet_first <= send ? head_beat.first : '0;
      recv_packet_last <= send ? head_beat.last : '0;
      recv_empty_qwords <= send ? head_beat.empty : '0;
    end
  end

  sequence accept_dropped;
    $fell(recv_sink_accept);
  endsequence

  sequence accept_raised_pending;
    $rose(recv_sink_accept) ##0 head_valid;
  endsequence

  // a wide end beat in single-packet mode entering the FIFO
  sequence single_wide_end;
    src_valid && src_ready && cfg_width == WIDTH_256 && !multi &&
      src_beat.last[0];
  endsequence

  // an end in either half entering the FIFO in multi-packet mode
  sequence multi_end_entry;
    src_valid && src_ready && multi && src_beat.last != 2'h0;
  endsequence

  valid_drop_a: assert property (
    @(posedge clock) disable iff (srst)
    accept_dropped |-> ##[1:2] !recv_beat_qualifier)
    else $error("valid stayed high after accept dropped");

  stall_quiet_a: assert property (
    @(posedge clock) disable iff (srst)
    stall_run >= 2'(READY_LATENCY) |-> !recv_beat_qualifier)
    else $error("beat sent during a stall");

  valid_return_a: assert property (
    @(posedge clock) disable iff (srst)
    accept_raised_pending |-> ##[1:2] recv_beat_qualifier)
    else $error("valid did not return after accept rose");

  ready_latency_a: assert property (
    @(posedge clock) disable iff (srst)
    recv_beat_qualifier |-> $past(recv_sink_accept, READY_LATENCY))
    else $error("beat sent outside a ready cycle");

  narrow_empty_a: assert property (
    @(posedge clock) disable iff (srst)
    cfg_width == WIDTH_64 |-> ##1 recv_empty_qwords == 2'h0)
    else $error("empty driven on narrow path");

  empty_on_last_a: assert property (
    @(posedge clock) disable iff (srst)
    recv_empty_qwords != 2'h0 |-> recv_beat_qualifier &&
    recv_packet_last != 2'h0)
    else $error("empty set outside an end beat");

  half_empty_a: assert property (
    @(posedge clock) disable iff (srst)
    $past(cfg_width) == WIDTH_128 |-> !recv_empty_qwords[1])
    else $error("upper empty bit used on 128-bit path");

  count_empty_a: assert property (
    @(posedge clock) disable iff (srst)
    single_wide_end |-> in_beat.empty == src_beat.empty)
    else $error("empty count altered on wide path");

  multi_empty_a: assert property (
    @(posedge clock) disable iff (srst)
    $past(multi) && recv_empty_qwords[1] |-> recv_packet_last[1])
    else $error("upper empty without upper end");

  low_empty_a: assert property (
    @(posedge clock) disable iff (srst)
    $past(multi) && recv_empty_qwords[0] |-> recv_packet_last[0])
    else $error("lower empty without lower end");

  half_keep_a: assert property (
    @(posedge clock) disable iff (srst)
    multi_end_entry |->
    in_beat.empty == (src_beat.empty & src_beat.last))
    else $error("per-half empty bit lost on entry");

  one_beat_a: assert property (
    @(posedge clock) disable iff (srst)
    send |=> recv_beat_qualifier && recv_payload_bus ==
    $past(head_beat.payload))
    else $error("sent beat not presented");

  single_last_a: assert property (
    @(posedge clock) disable iff (srst)
    $past(!multi) |-> !recv_packet_last[1])
    else $error("upper last bit set outside multi-packet mode");

  fields_idle_a: assert property (
    @(posedge clock) disable iff (srst)
    !recv_beat_qualifier |-> recv_packet_first == 2'h0 &&
    recv_packet_last == 2'h0)
    else $error("packet marks set without a beat");

  wide_code_a: assert property (
    @(posedge clock) disable iff (srst)
    cfg_width != WIDTH_128 && cfg_width != WIDTH_256 |->
    in_beat.empty == 2'h0)
    else $error("empty kept on a path without empty");
endmodule

/* tb/rsef_app_model.sv */
/* application-side model: throttles via accept and logs beats.
   assumes it shares the clock of the stream stage */
`timescale 1ns/1ns
module rsef_app_model (
  input wire logic clock,
  input wire logic stall,
  input wire logic recv_beat_qualifier,
  input wire logic [rsef_pkg::DATA_W-1:0] recv_payload_bus,
  input wire logic [rsef_pkg::EOP_W-1:0] recv_packet_first,
  input wire logic [rsef_pkg::EOP_W-1:0] recv_packet_last,
  input wire logic [rsef_pkg::EMPTY_W-1:0] recv_empty_qwords,
  output logic recv_sink_accept
);
  import rsef_pkg::*;
  rsef_beat_type seen[$];
  assign recv_sink_accept = !stall;
  // empty is junk off end beats, so it is logged as zero there
  always @(posedge clock) begin
    if (recv_beat_qualifier) begin
      seen.push_back({recv_payload_bus, recv_packet_first, recv_packet_last,
        recv_packet_last != 0 ? recv_empty_qwords : 2'h0});
    end
  end
endmodule

/* tb/rsef_rx_stream_tb.sv */
/* self-checking bench for the receive stream stage.
   assumes the application model in rsef_app_model */
`timescale 1ns/1ns
module rsef_rx_stream_tb;
  import rsef_pkg::*;
  logic clock = 0, srst = 1, src_valid = 0, stall = 1, multi = 0;
  logic [1:0] width = WIDTH_128;
  rsef_beat_type src_beat = '0;
  rsef_beat_type expq[$];
  logic src_ready, qual, accept;
  logic [DATA_W-1:0] pay;
  logic [1:0] fst, lst, emp;
  int fail_count = 0, compares = 0;
  always #2 clock = ~clock;
  rsef_rx_stream DUT (.clock(clock), .srst(srst), .cfg_width(width),
    .cfg_multi_packet(multi), .src_valid(src_valid),
    .src_ready(src_ready), .src_beat(src_beat),
    .recv_sink_accept(accept), .recv_beat_qualifier(qual),
    .recv_payload_bus(pay), .recv_packet_first(fst),
    .recv_packet_last(lst), .recv_empty_qwords(emp));
  rsef_app_model app (.clock(clock), .stall(stall),
    .recv_beat_qualifier(qual), .recv_payload_bus(pay),
    .recv_packet_first(fst), .recv_packet_last(lst),
    .recv_empty_qwords(emp), .recv_sink_accept(accept));
  task automatic conclude;
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bad(input string m);
    $display("unexpected %0t %s", $time, m);
    fail_count++;
  endtask
  function automatic rsef_beat_type clean(rsef_beat_type b);
    rsef_beat_type e = b;
    if (!(multi && width == WIDTH_256)) begin
      e.first[1] = 1'b0;
      e.last[1] = 1'b0;
    end
    if (e.last == 0 || width == WIDTH_64) e.empty = 0;
    else if (width == WIDTH_128) e.empty[1] = 1'b0;
    else if (width != WIDTH_256) e.empty = 0;
    else if (multi) e.empty = b.empty & e.last;
    return e;
  endfunction
  task automatic send(input int k, input logic [1:0] l, input logic [1:0] e);
    int n;
    @(posedge clock);
    #1 src_valid = 1;
    src_beat = {{4{64'h0123_4567_89AB_CDEF}} ^ DATA_W'(k), l, l, e};
    for (n = 0; n < 50 && src_ready !== 1'b1; n++) @(posedge clock) #1;
    if (n == 50) begin bad("source stuck"); conclude; end
    expq.push_back(clean(src_beat));
    @(posedge clock);
    #1 src_valid = 0;
  endtask
  // beats must arrive whole and in order once the model stops stalling
  task automatic drain;
    int n;
    stall = 0;
    for (n = 0; n < 100 && app.seen.size() < expq.size(); n++)
      @(posedge clock) #1;
    stall = 1;
    compares++;
    if (app.seen.size() != expq.size()) begin
      bad("count");
      conclude;
    end
    foreach (expq[i]) begin
      compares++;
      if (app.seen[i] !== expq[i]) bad("beat fields");
    end
    expq.delete();
    app.seen.delete();
  endtask
  task automatic await(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && qual !== v; n++) @(posedge clock) #1;
    compares++;
    if (qual !== v) bad("qualifier timing");
  endtask
  task automatic t_modes;
    width = WIDTH_128;
    send(1, 2'h1, 2'h3);
    send(2, 2'h0, 2'h1);
    send(3, 2'h2, 2'h3);
    drain();
    width = WIDTH_256;
    for (int e = 0; e < 4; e++) send(e, 2'h1, 2'(e));
    send(4, 2'h2, 2'h3);
    drain();
    multi = 1;
    send(5, 2'h3, 2'h2);
    send(6, 2'h1, 2'h3);
    send(7, 2'h2, 2'h3);
    drain();
    multi = 0;
    width = WIDTH_64;
    send(8, 2'h1, 2'h3);
    drain();
  endtask
  task automatic t_backpressure;
    width = WIDTH_128;
    for (int k = 0; k < FIFO_DEPTH; k++) send(k, 2'(k & 1), 2'h1);
    compares++;
    if (src_ready !== 1'b0 || qual !== 1'b0) bad("full");
    stall = 0;
    @(posedge clock) #1 compares++;
    if (qual !== 1'b0) bad("beat before ready cycle");
    await(1'b1, 1);
    stall = 1;
    await(1'b0, 2);
    repeat (6) begin
      @(posedge clock) #1 compares++;
      if (qual !== 1'b0) bad("beat while stalled");
    end
    drain();
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #1 srst = 0;
    t_modes();
    t_backpressure();
    conclude();
  end
endmodule
